// ### src/sleep_wake_pkg.sv
// shared constants and types of the sleep, wake and external interrupt control
package sleep_wake_pkg;
    // register map (byte addresses on the register bus)
    localparam logic [11:0] CTRL_IDX = 12'h035;
    localparam logic [11:0] CTRL_ADDR = CTRL_IDX << 2;
    localparam logic [11:0] IMASK_ADDR = 12'h100;
    localparam logic [11:0] CMPCTL_ADDR = 12'h104;
    localparam logic [11:0] ISTAT_ADDR = 12'h108;
    localparam logic [11:0] ICLR_ADDR = 12'h10c;
    localparam logic [11:0] IEN_ADDR = 12'h110;
    localparam logic [11:0] STATE_ADDR = 12'h114;
    // control register fields
    localparam int SLP_EN_POS = 5;
    localparam int MODE_SEL_POS = 4;
    localparam int ISC1_POS = 1;
    localparam int ISC0_POS = 0;
    localparam logic [7:0] CTRL_RW_MASK = 8'h33;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int MASK_IRQ_POS = 6;
    localparam int CMP_DIS_POS = 7;
    localparam logic [7:0] IMASK_RESET = 8'h00;
    localparam logic [7:0] CMPCTL_RESET = 8'h00;
    // sense codes
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_RSVD = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    // event status bits
    localparam int EV_WAKE = 0;
    localparam int EV_WDOG = 1;
    localparam int EV_EXT = 2;
    localparam int EV_N = 3;
    // time-out in clock cycles
    localparam int TOUT_CYC = 16;
    localparam logic [15:0] TOUT_RESET = 16'h0000;

    typedef enum logic [4:0] {
        ST_HOLD  = 5'h01,
        ST_RUN   = 5'h02,
        ST_IDLE  = 5'h04,
        ST_PDOWN = 5'h08,
        ST_WAKE  = 5'h10
    } pstate_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage

// ### src/sleep_wake_ext_irq_control.sv
// sleep, wake-up, reset delay and external interrupt sense control
// Functional notes
// - low reset pin resets the block asynchronously, clock not needed.
// - after reset release the delay timer runs, then processor released.
// - watchdog pulse resets; timer counts from its falling edge.
// - control register resets to zero; bits 7,6,3,2 read zero.
// - sleep request enters sleep only when sleep enable is one.
// - mode select zero gives idle, one gives power-down.
// - sense field picks low level, reserved, falling or rising edge.
// - interrupt taken only with global enable and mask bit set.
// - pin sampled before edge detection; pulses over one clock seen.
// - low level requests while pin stays low at instruction end.
// - enabled interrupt wakes sleep; registers are kept.
// - any reset during sleep wakes to the reset vector.
// - idle keeps timers and interrupts; any interrupt wakes at once.
// - power-down stops oscillator; only resets or level irq wake.
// - power-down level wake needs low longer than the time-out.
// - comparator disable powers comparator down; its irq cannot wake.
`timescale 1ns/1ps
module sleep_wake_ext_irq_control #(
    parameter int TOUT = sleep_wake_pkg::TOUT_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // register bus
    input wire sleep_wake_pkg::apb_req_t APB_REQ,
    output sleep_wake_pkg::apb_rsp_t APB_RSP,
    // core side
    input wire logic SLEEP_REQ,
    input wire logic INSN_DONE,
    input wire logic GLOBAL_IE,
    input wire logic WDOG_PULSE,
    input wire logic TIMER_IRQ,
    input wire logic CMP_IRQ,
    input wire logic EXT_IRQ_PIN,
    output logic CPU_RUN,
    output logic OSC_EN,
    output logic RESET_VECTOR,
    output logic EXT_IRQ_REQ,
    output logic CMP_POWER,
    output logic IRQ
);
    import sleep_wake_pkg::*;

    logic [7:0] ctrl_q;
    logic [7:0] imask_q;
    logic [7:0] cmpctl_q;
    logic [EV_N-1:0] ist_q;
    logic [EV_N-1:0] ien_q;
    pstate_t st_q;
    pstate_t st_d;
    logic [15:0] tout_q;
    logic wd_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_prev_q;
    logic ext_req_q;
    logic [15:0] low_cnt_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic cpu_run_q;
    logic rstvec_q;
    logic irq_q;

    wire apb_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && pready_q;
    wire apb_rd = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && pready_q;
    wire [1:0] sense = {ctrl_q[ISC1_POS], ctrl_q[ISC0_POS]};
    wire wd_fall = wd_q && !WDOG_PULSE;
    wire ext_en = GLOBAL_IE && imask_q[MASK_IRQ_POS];
    wire low_wake = (low_cnt_q >= 16'(TOUT));
    wire cmp_wake = CMP_IRQ && !cmpctl_q[CMP_DIS_POS];

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    // two-flop sample of the pin, edges seen only after the second
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_s1_q <= EXT_IRQ_PIN;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // request generation per sense code
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ext_req_q <= 1'b0;
        end else begin
            unique case (sense)
                SENSE_LOW: ext_req_q <= !pin_s2_q && INSN_DONE;
                SENSE_RSVD: ext_req_q <= 1'b0;
                SENSE_FALL: ext_req_q <= pin_prev_q && !pin_s2_q;
                SENSE_RISE: ext_req_q <= !pin_prev_q && pin_s2_q;
            endcase
        end
    end

    // low-level duration for power-down wake
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            low_cnt_q <= 16'h0000;
        end else if (pin_s2_q || sense != SENSE_LOW) begin
            low_cnt_q <= 16'h0000;
        end else if (!low_wake) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    // watchdog pulse edge tracking
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wd_q <= 1'b0;
        end else begin
            wd_q <= WDOG_PULSE;
        end
    end

    // reset delay timer, restarted while watchdog pulse is high
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tout_q <= TOUT_RESET;
        end else if (WDOG_PULSE) begin
            tout_q <= TOUT_RESET;
        end else if (st_q == ST_HOLD && tout_q != 16'(TOUT)) begin
            tout_q <= tout_q + 16'h0001;
        end
    end

    // power state sequencing
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_HOLD: if (tout_q == 16'(TOUT) && !WDOG_PULSE) st_d = ST_RUN;
            ST_RUN: begin
                if (SLEEP_REQ && ctrl_q[SLP_EN_POS]) begin
                    st_d = ctrl_q[MODE_SEL_POS] ? ST_PDOWN : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if ((ext_req_q && ext_en) || TIMER_IRQ || cmp_wake) begin
                    st_d = ST_WAKE;
                end
            end
            ST_PDOWN: if (low_wake && ext_en) st_d = ST_WAKE;
            ST_WAKE: st_d = ST_RUN;
            default: st_d = ST_HOLD;
        endcase
        if (WDOG_PULSE) st_d = ST_HOLD;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q <= ST_HOLD;
        end else begin
            st_q <= st_d;
        end
    end

    // core facing outputs
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cpu_run_q <= 1'b0;
            rstvec_q <= 1'b1;
        end else begin
            cpu_run_q <= (st_d == ST_RUN) || (st_d == ST_WAKE);
            // reset vector held until the processor has been released
            rstvec_q <= (st_d == ST_HOLD);
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            OSC_EN <= 1'b1;
            EXT_IRQ_REQ <= 1'b0;
            CMP_POWER <= 1'b1;
        end else begin
            OSC_EN <= (st_d != ST_PDOWN);
            EXT_IRQ_REQ <= ext_req_q && ext_en;
            CMP_POWER <= !cmpctl_q[CMP_DIS_POS];
        end
    end

    // control, mask and comparator registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q <= CTRL_RESET;
            imask_q <= IMASK_RESET;
            cmpctl_q <= CMPCTL_RESET;
            ien_q <= '0;
        end else if (apb_wr) begin
            if (hit(APB_REQ.paddr, CTRL_ADDR)) begin
                ctrl_q <= APB_REQ.pwdata[7:0] & CTRL_RW_MASK;
            end
            if (hit(APB_REQ.paddr, IMASK_ADDR)) imask_q <= APB_REQ.pwdata[7:0];
            if (hit(APB_REQ.paddr, CMPCTL_ADDR)) cmpctl_q <= APB_REQ.pwdata[7:0];
            if (hit(APB_REQ.paddr, IEN_ADDR)) ien_q <= APB_REQ.pwdata[EV_N-1:0];
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ist_q <= '0;
        end else begin
            logic [EV_N-1:0] set_v;
            logic [EV_N-1:0] clr_v;
            set_v = '0;
            set_v[EV_WAKE] = (st_q == ST_WAKE);
            set_v[EV_WDOG] = wd_fall;
            set_v[EV_EXT] = ext_req_q && ext_en;
            clr_v = (apb_wr && hit(APB_REQ.paddr, ICLR_ADDR)) ?
                APB_REQ.pwdata[EV_N-1:0] : '0;
            ist_q <= (ist_q & ~clr_v) | set_v;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ist_q & ien_q);
        end
    end

    // bus slave: one wait state so read data comes from a flop
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= APB_REQ.psel && APB_REQ.penable && !pready_q;
            if (APB_REQ.psel && !APB_REQ.pwrite) begin
                unique case (APB_REQ.paddr)
                    CTRL_ADDR: prdata_q <= {24'h000000, ctrl_q & CTRL_RW_MASK};
                    IMASK_ADDR: prdata_q <= {24'h000000, imask_q};
                    CMPCTL_ADDR: prdata_q <= {24'h000000, cmpctl_q};
                    ISTAT_ADDR: prdata_q <= {29'h00000000, ist_q};
                    IEN_ADDR: prdata_q <= {29'h00000000, ien_q};
                    STATE_ADDR: prdata_q <= {27'h0000000, st_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign APB_RSP.pready = pready_q;
    assign APB_RSP.pslverr = 1'b0;
    assign APB_RSP.prdata = prdata_q;
    assign CPU_RUN = cpu_run_q;
    assign RESET_VECTOR = rstvec_q;
    assign IRQ = irq_q;

    // checks share the block clock; the reset pin disables them
    a_sleep_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_RUN && SLEEP_REQ && !ctrl_q[SLP_EN_POS] && !WDOG_PULSE)
        |=> st_q == ST_RUN)
        else $error("sleep entered with enable clear");
    a_mode_select: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_RUN && SLEEP_REQ && ctrl_q[SLP_EN_POS] && !WDOG_PULSE)
        |=> st_q == (ctrl_q[MODE_SEL_POS] ? ST_PDOWN : ST_IDLE))
        else $error("wrong sleep mode");
    a_rsvd_bits: assert property (@(posedge CLK) disable iff (!ARST_N)
        (ctrl_q & ~CTRL_RW_MASK) == 8'h00
        )
        else $error("reserved bits set");
    a_rsvd_sense: assert property (@(posedge CLK) disable iff (!ARST_N)
        (sense == SENSE_RSVD)
        |=> !ext_req_q)
        else $error("reserved sense requested");
    a_fall_edge: assert property (@(posedge CLK) disable iff (!ARST_N)
        (sense == SENSE_FALL && $fell(pin_s2_q) && $stable(sense))
        |=> ext_req_q)
        else $error("falling edge missed");
    a_irq_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
        EXT_IRQ_REQ
        |-> $past(ext_en))
        else $error("request without enables");
    a_pdown_osc: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_PDOWN)
        |-> !OSC_EN)
        else $error("oscillator runs in power-down");
    a_pdown_short: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_PDOWN && !low_wake && !WDOG_PULSE)
        |=> st_q == ST_PDOWN)
        else $error("woke on short low");
    a_wdog_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
        WDOG_PULSE
        |=> st_q == ST_HOLD && !CPU_RUN)
        else $error("watchdog not reset");
    a_cmp_off: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_IDLE && cmpctl_q[CMP_DIS_POS] && !TIMER_IRQ && !WDOG_PULSE
        && !(ext_req_q && ext_en)) |=> st_q == ST_IDLE)
        else $error("disabled comparator woke idle");

    // multi-step behaviours, three of them built from named sequences
    sequence s_hold_done;
        st_q == ST_HOLD && tout_q == 16'(TOUT) && !WDOG_PULSE;
    endsequence
    sequence s_idle_wake;
        st_q == ST_IDLE && !WDOG_PULSE && ((ext_req_q && ext_en) || TIMER_IRQ || cmp_wake);
    endsequence
    sequence s_pdown_wake;
        st_q == ST_PDOWN && !WDOG_PULSE && low_wake && ext_en;
    endsequence

    a_hold_wait: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_HOLD && tout_q != 16'(TOUT))
        |=> st_q == ST_HOLD)
        else $error("processor released before time-out");
    a_hold_release: assert property (@(posedge CLK) disable iff (!ARST_N)
        s_hold_done
        |=> st_q == ST_RUN && CPU_RUN)
        else $error("processor not released after time-out");
    a_wdog_restart: assert property (@(posedge CLK) disable iff (!ARST_N)
        $fell(WDOG_PULSE)
        |-> tout_q == TOUT_RESET && st_q == ST_HOLD)
        else $error("delay timer not restarted by watchdog");
    a_rise_edge: assert property (@(posedge CLK) disable iff (!ARST_N)
        (sense == SENSE_RISE && $rose(pin_s2_q) && $stable(sense))
        |=> ext_req_q)
        else $error("rising edge missed");
    a_low_level: assert property (@(posedge CLK) disable iff (!ARST_N)
        (sense == SENSE_LOW && !pin_s2_q && INSN_DONE)
        |=> ext_req_q)
        else $error("low level not requesting");
    a_low_busy: assert property (@(posedge CLK) disable iff (!ARST_N)
        (sense == SENSE_LOW && !INSN_DONE)
        |=> !ext_req_q)
        else $error("low level requested mid instruction");
    a_idle_wake: assert property (@(posedge CLK) disable iff (!ARST_N)
        s_idle_wake
        |=> st_q == ST_WAKE && CPU_RUN)
        else $error("idle did not wake at once");
    a_wake_resume: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_WAKE && !WDOG_PULSE)
        |=> st_q == ST_RUN && CPU_RUN && !RESET_VECTOR)
        else $error("wake did not resume execution");
    a_pdown_wake: assert property (@(posedge CLK) disable iff (!ARST_N)
        s_pdown_wake
        |=> st_q == ST_WAKE && OSC_EN)
        else $error("long low did not wake power-down");
    a_osc_follow: assert property (@(posedge CLK) disable iff (!ARST_N)
        OSC_EN == (st_q != ST_PDOWN)
        )
        else $error("oscillator enable off its state");
    a_reset_vector: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_HOLD)
        |-> RESET_VECTOR && !CPU_RUN)
        else $error("reset vector not held in delay");
    a_cmp_power: assert property (@(posedge CLK) disable iff (!ARST_N)
        cmpctl_q[CMP_DIS_POS]
        |=> !CMP_POWER)
        else $error("comparator powered while disabled");
    a_mask_off: assert property (@(posedge CLK) disable iff (!ARST_N)
        !ext_en
        |=> !EXT_IRQ_REQ)
        else $error("request while masked");
    a_sleep_cpu: assert property (@(posedge CLK) disable iff (!ARST_N)
        (st_q == ST_RUN && SLEEP_REQ && ctrl_q[SLP_EN_POS] && !WDOG_PULSE)
        |=> !CPU_RUN)
        else $error("processor kept running in sleep");
endmodule // sleep_wake_ext_irq_control

// ### testbench/irq_pin_source.sv
// external reset source and interrupt pin driver model
`timescale 1ns/1ps
module irq_pin_source (
    // clock
    input wire logic clk,
    // pins into the block
    output logic rst_n,
    output logic pin
);
    // pin idles high, as under a pull-up
    initial begin
        rst_n = 1'b0;
        pin = 1'b1;
    end
    task automatic reset_for(input int n);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // a level wake only counts if the low outlasts the time-out
    task automatic hold_low(input int n);
        @(posedge clk);
        pin <= 1'b0;
        repeat (n) @(posedge clk);
        pin <= 1'b1;
    endtask
endmodule // irq_pin_source

// ### testbench/tb_sleep_wake_ext_irq_control.sv
// self-checking bench of the sleep, wake and interrupt control
`timescale 1ns/1ps
module tb_sleep_wake_ext_irq_control;
    import sleep_wake_pkg::*;
    // short time-out keeps the run brief
    localparam int TOUT = 4;
    logic clk, arst_n, pin, slp, done, gie, wdog, tmr, cmp;
    logic run, osc, rvec, ereq, cpow, irq;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [31:0] rdata;
    logic rerr;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int seen;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    irq_pin_source irq_pin_source_inst (.clk(clk), .rst_n(arst_n), .pin(pin));
    sleep_wake_ext_irq_control #(.TOUT(TOUT)) sleep_wake_ext_irq_control_inst (
        .CLK(clk), .ARST_N(arst_n), .APB_REQ(req), .APB_RSP(rsp),
        .SLEEP_REQ(slp), .INSN_DONE(done), .GLOBAL_IE(gie), .WDOG_PULSE(wdog),
        .TIMER_IRQ(tmr), .CMP_IRQ(cmp), .EXT_IRQ_PIN(pin), .CPU_RUN(run),
        .OSC_EN(osc), .RESET_VECTOR(rvec), .EXT_IRQ_REQ(ereq),
        .CMP_POWER(cpow), .IRQ(irq));

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk_w(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_b(input string s, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", s, e, g);
        end
    endtask

    // request held until the edge that samples pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        // pready and read data are taken at the same rising edge
        while (rsp.pready !== 1'b1) @(posedge clk);
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_w(s, e, rdata);
        chk_b("pslverr", 1'b0, rerr);
    endtask
    task automatic sleep_op();
        @(posedge clk);
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
    endtask
    task automatic wait_run(input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (run !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk_b("cpu_run", 1'b1, run);
        @(posedge clk);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(negedge clk);
        chk_b("irq", e, irq);
        @(posedge clk);
    endtask
    // two-cycle low pulse while counting request cycles over ten cycles
    task automatic sense(input logic [1:0] c, input logic e, input string s);
        seen = 0;
        wr(CTRL_ADDR, {30'h0, c});
        fork
            irq_pin_source_inst.hold_low(2);
            repeat (10) begin
                @(negedge clk);
                if (ereq === 1'b1) seen++;
            end
        join
        chk_b(s, e, seen != 0);
        @(posedge clk);
    endtask

    initial begin
        req = '0;
        slp = 1'b0;
        done = 1'b1;
        gie = 1'b0;
        wdog = 1'b0;
        tmr = 1'b0;
        cmp = 1'b0;
        @(negedge clk);
        chk_b("rvec", 1'b1, rvec);
        chk_b("run_rst", 1'b0, run);
        irq_pin_source_inst.reset_for(3);
        repeat (TOUT) @(negedge clk);
        chk_b("run_early", 1'b0, run);
        wait_run(20);
        rd("ctrl_rst", CTRL_ADDR, 32'h0);
        wr(CTRL_ADDR, 32'hff);
        rd("ctrl_rw", CTRL_ADDR, 32'h33);
        rd("unmapped", 12'h0f0, 32'h0);
        wr(IMASK_ADDR, 32'h40);
        gie <= 1'b1;
        sense(SENSE_LOW, 1'b1, "low");
        sense(SENSE_RSVD, 1'b0, "rsvd");
        sense(SENSE_FALL, 1'b1, "fall");
        sense(SENSE_RISE, 1'b1, "rise");
        done <= 1'b0;
        sense(SENSE_LOW, 1'b0, "busy");
        done <= 1'b1;
        gie <= 1'b0;
        sense(SENSE_FALL, 1'b0, "gie_off");
        gie <= 1'b1;
        wr(IMASK_ADDR, 32'h0);
        sense(SENSE_FALL, 1'b0, "mask_off");
        wr(IMASK_ADDR, 32'h40);
        rd("istat", ISTAT_ADDR, 32'h4);
        wr(IEN_ADDR, 32'h4);
        irq_is(1'b1);
        wr(IEN_ADDR, 32'h0);
        irq_is(1'b0);
        wr(IEN_ADDR, 32'h4);
        wr(ICLR_ADDR, 32'h4);
        irq_is(1'b0);
        wr(ISTAT_ADDR, 32'h7);
        rd("istat_ro", ISTAT_ADDR, 32'h0);
        wr(CTRL_ADDR, 32'h0);
        sleep_op();
        rd("no_se", STATE_ADDR, 32'h2);
        wr(CMPCTL_ADDR, 32'h80);
        wr(CTRL_ADDR, 32'h20);
        sleep_op();
        rd("idle", STATE_ADDR, 32'h4);
        chk_b("cmp_pow", 1'b0, cpow);
        cmp <= 1'b1;
        rd("cmp_off", STATE_ADDR, 32'h4);
        cmp <= 1'b0;
        tmr <= 1'b1;
        wait_run(10);
        tmr <= 1'b0;
        rd("kept", CTRL_ADDR, 32'h20);
        wr(CTRL_ADDR, 32'h32);
        sleep_op();
        rd("pdown", STATE_ADDR, 32'h8);
        chk_b("osc_off", 1'b0, osc);
        irq_pin_source_inst.hold_low(2);
        rd("pd_edge", STATE_ADDR, 32'h8);
        wr(CTRL_ADDR, 32'h30);
        irq_pin_source_inst.hold_low(TOUT - 2);
        rd("pd_short", STATE_ADDR, 32'h8);
        irq_pin_source_inst.hold_low(TOUT + 8);
        wait_run(20);
        chk_b("osc_on", 1'b1, osc);
        wr(CTRL_ADDR, 32'h20);
        sleep_op();
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        repeat (2) @(negedge clk);
        chk_b("wd_rvec", 1'b1, rvec);
        wait_run(20);
        irq_pin_source_inst.reset_for(2);
        rd("ctrl_rst2", CTRL_ADDR, 32'h0);
        tally_and_finish();
    end
endmodule // tb_sleep_wake_ext_irq_control
